// ---- hw/otc_pkg.sv ----
// Purpose: shared constants and types for the on-chip trace capture block
// Assumes: 24-bit address bus, 16-bit data bus, 8 interrupt request pins
// Notes:   register offsets are word indices on the plain register port
package otc_pkg;
	localparam int ADDR_W  = 24;
	localparam int DATA_W  = 16;
	localparam int IRQ_W   = 8;
	localparam int DEPTH   = 16;
	localparam int PTR_W   = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int CLKS_W  = 8;
	localparam int RADDR_W = 4;
	// register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_AMATCH = 4'h1;
	localparam logic [3:0] OFS_AMASK  = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_RPOS   = 4'h4;
	localparam logic [3:0] OFS_RADDR  = 4'h5;
	localparam logic [3:0] OFS_RDATA  = 4'h6;
	localparam logic [3:0] OFS_RINFO  = 4'h7;
	// control fields
	localparam int CTRL_BUS_MODE = 0;
	localparam int CTRL_FULL     = 1;
	localparam int CTRL_SUP_FETCH = 2;
	localparam int CTRL_SUP_DATA = 3;
	localparam int CTRL_SUP_DXC  = 4;
	localparam int CTRL_SUP_DMA  = 5;
	localparam int CTRL_ADDR_EN  = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [5:0] AMASK_RST = 6'h00;

	typedef enum logic [2:0] {
		CLS_DMA, CLS_DXC, CLS_FETCH, CLS_DATA, CLS_REFRESH
	} otc_cls_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              wr;
		logic [2:0]        area;
		otc_cls_t          cls;
		logic [IRQ_W-1:0]  irq;
	} otc_bus_t;

	typedef struct packed {
		logic              is_bus;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              wr;
		logic [2:0]        area;
		otc_cls_t          cls;
		logic [CLKS_W-1:0] clks;
		logic [IRQ_W-1:0]  irq;
	} otc_rec_t;

	localparam int REC_W = $bits(otc_rec_t);
endpackage

// ---- hw/otc_fifo.sv ----
// Purpose: small valid/ready fifo between the capture filter and the trace store
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ns
module otc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             CLK,
	input  wire logic             NRST,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} otc_fifo_st_t;
	otc_fifo_st_t     st_r, st_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             full, empty;

	assign full      = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
	assign empty     = st_r.wp == st_r.rp;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[st_r.rp[AW-1:0]];

	always_comb begin
		st_nxt = st_r;
		if (in_valid && !full)
			st_nxt.wp = st_r.wp + 1'b1;
		if (out_ready && !empty)
			st_nxt.rp = st_r.rp + 1'b1;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	always_ff @(posedge CLK) begin
		if (in_valid && !full)
			mem[st_r.wp[AW-1:0]] <= in_data;
	end
endmodule

// ---- hw/otc_top.sv ----
// Purpose: on-chip trace capture of branch sources or bus cycles into a circular buffer
// Assumes: observed bus signals are synchronous to CLK; one strobe per event
// Notes:   branch and bus records share one store; newest entry is position +0
//
// Behaviour
// - capture runs alongside the processor, never stalling or slowing it.
// - trace type selects branch or bus records; only that kind is stored.
// - every taken branch stores one record with the branch source address.
// - bus records hold address, data, direction, area, irq pins and cycle class.
// - branch records carry no bus fields; bus records carry no branch type.
// - suppression and address condition apply only in bus recording.
// - full-capture option records every bus cycle regardless of class.
// - four suppress bits each block fetch, data, transfer-controller or dma cycles.
// - optional address condition with per-hex-digit don't-care mask.
// - read position is signed relative to newest entry, +0 newest, older negative.
// - each bus record holds the clock count of its bus cycle.
// - fixed-depth buffer; when full the oldest record is overwritten.
// - stored class tells dma, transfer-controller, fetch, data and refresh apart.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module otc_top (
	// clock and reset
	input  wire logic                        CLK,
	input  wire logic                        NRST,
	// observed processor side
	input  wire logic                        BRANCH_TAKEN,
	input  wire logic [otc_pkg::ADDR_W-1:0]  BRANCH_SRC,
	input  wire logic                        BUS_START,
	input  wire otc_pkg::otc_bus_t           BUS_END,
	// register port
	input  wire logic [otc_pkg::RADDR_W-1:0] REG_ADDR,
	input  wire logic [31:0]                 REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output logic [31:0]                      REG_RDATA,
	// status
	output logic                             TRACE_NONEMPTY
);
	typedef struct packed {
		logic [6:0]                  ctrl;
		logic [otc_pkg::ADDR_W-1:0]  amatch;
		logic [5:0]                  amask;
		logic [otc_pkg::PTR_W-1:0]   wptr;
		logic [otc_pkg::PTR_W:0]     count;
		logic [otc_pkg::PTR_W-1:0]   rpos;
		logic [otc_pkg::CLKS_W-1:0]  clks;
		logic [31:0]                 rdata;
		logic                        dropped;
	} otc_st_t;

	otc_st_t           st_r, st_nxt;
	otc_pkg::otc_rec_t store [otc_pkg::DEPTH];
	otc_pkg::otc_rec_t cand, fifo_out, sel_rec;
	logic              cand_valid, fifo_in_ready, fifo_valid;
	logic              bus_mode, addr_hit, class_ok, wr_store;
	logic [otc_pkg::PTR_W-1:0] rd_idx;
	logic [otc_pkg::CLKS_W-1:0] clks_now;

	// count includes the current clock, so a one-clock cycle reads 1
	always_comb begin
		if (BUS_START)
			clks_now = 8'h01;
		else if (st_r.clks != 8'hff)
			clks_now = st_r.clks + 8'h01;
		else
			clks_now = st_r.clks;
	end

	// -----------------------------
	// address digit matching
	// -----------------------------
	function automatic logic digits_match(input logic [otc_pkg::ADDR_W-1:0] a,
		input logic [otc_pkg::ADDR_W-1:0] m, input logic [5:0] msk);
		logic ok;
		ok = 1'b1;
		for (int d = 0; d < 6; d++) begin
			if (!msk[d] && (a[d*4 +: 4] != m[d*4 +: 4]))
				ok = 1'b0;
		end
		return ok;
	endfunction

	// -----------------------------
	// capture filter
	// -----------------------------
	assign bus_mode = st_r.ctrl[otc_pkg::CTRL_BUS_MODE];
	assign addr_hit = !st_r.ctrl[otc_pkg::CTRL_ADDR_EN] ||
		digits_match(BUS_END.addr, st_r.amatch, st_r.amask);

	always_comb begin
		class_ok = 1'b1;
		if (!st_r.ctrl[otc_pkg::CTRL_FULL]) begin
			case (BUS_END.cls)
			otc_pkg::CLS_FETCH: class_ok = !st_r.ctrl[otc_pkg::CTRL_SUP_FETCH];
			otc_pkg::CLS_DATA:  class_ok = !st_r.ctrl[otc_pkg::CTRL_SUP_DATA];
			otc_pkg::CLS_DXC:   class_ok = !st_r.ctrl[otc_pkg::CTRL_SUP_DXC];
			otc_pkg::CLS_DMA:   class_ok = !st_r.ctrl[otc_pkg::CTRL_SUP_DMA];
			default:            class_ok = 1'b1;
			endcase
		end
	end

	always_comb begin
		cand       = '0;
		cand_valid = 1'b0;
		if (bus_mode) begin
			cand_valid  = BUS_END.valid && class_ok && addr_hit;
			cand.is_bus = 1'b1;
			cand.addr   = BUS_END.addr;
			cand.data   = BUS_END.data;
			cand.wr     = BUS_END.wr;
			cand.area   = BUS_END.area;
			cand.cls    = BUS_END.cls;
			cand.irq    = BUS_END.irq;
			cand.clks   = clks_now;
		end else begin
			cand_valid = BRANCH_TAKEN;
			cand.addr  = BRANCH_SRC;
		end
	end

	// -----------------------------
	// decoupling fifo
	// -----------------------------
	// the store always drains, so the fifo never backs up into the core
	otc_fifo #(
		.WIDTH (otc_pkg::REC_W),
		.DEPTH (otc_pkg::FIFO_DEPTH)
	) u_fifo (
		.CLK       (CLK),
		.NRST      (NRST),
		.in_valid  (cand_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (cand),
		.out_valid (fifo_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out)
	);
	assign wr_store = fifo_valid;

	// -----------------------------
	// readout
	// -----------------------------
	// position 0 is newest; rpos holds the negated offset
	assign rd_idx  = st_r.wptr - 4'h1 - st_r.rpos;
	assign sel_rec = store[rd_idx];

	// -----------------------------
	// state update
	// -----------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.clks = clks_now;
		if (wr_store) begin
			st_nxt.wptr = st_r.wptr + 4'h1;
			if (st_r.count != 5'h10)
				st_nxt.count = st_r.count + 5'h01;
		end
		if (REG_WR) begin
			if (REG_ADDR == otc_pkg::OFS_CTRL)
				st_nxt.ctrl = REG_WDATA[6:0];
			else if (REG_ADDR == otc_pkg::OFS_AMATCH)
				st_nxt.amatch = REG_WDATA[otc_pkg::ADDR_W-1:0];
			else if (REG_ADDR == otc_pkg::OFS_AMASK)
				st_nxt.amask = REG_WDATA[5:0];
			else if (REG_ADDR == otc_pkg::OFS_RPOS)
				st_nxt.rpos = 4'h0 - REG_WDATA[3:0];
			else if (REG_ADDR == otc_pkg::OFS_STATUS && REG_WDATA[0])
				st_nxt.dropped = 1'b0;
		end
		// set after the clear so an overflow in the clear cycle is kept
		if (cand_valid && !fifo_in_ready)
			st_nxt.dropped = 1'b1;
		st_nxt.rdata = 32'h0;
		if (REG_RD) begin
			if (REG_ADDR == otc_pkg::OFS_CTRL)
				st_nxt.rdata = {25'h0, st_r.ctrl};
			else if (REG_ADDR == otc_pkg::OFS_AMATCH)
				st_nxt.rdata = {8'h0, st_r.amatch};
			else if (REG_ADDR == otc_pkg::OFS_AMASK)
				st_nxt.rdata = {26'h0, st_r.amask};
			else if (REG_ADDR == otc_pkg::OFS_STATUS)
				st_nxt.rdata = {19'h0, st_r.count, st_r.wptr, 3'h0, st_r.dropped};
			else if (REG_ADDR == otc_pkg::OFS_RPOS)
				st_nxt.rdata = {28'h0, 4'h0 - st_r.rpos};
			else if (REG_ADDR == otc_pkg::OFS_RADDR)
				st_nxt.rdata = {sel_rec.is_bus, 7'h0, sel_rec.addr};
			else if (REG_ADDR == otc_pkg::OFS_RDATA)
				st_nxt.rdata = {sel_rec.irq, 8'h0, sel_rec.data};
			else if (REG_ADDR == otc_pkg::OFS_RINFO)
				st_nxt.rdata = {16'h0, sel_rec.clks, sel_rec.wr, sel_rec.area,
					1'b0, sel_rec.cls};
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_r        <= '0;
			st_r.ctrl   <= otc_pkg::CTRL_RST;
			st_r.amask  <= otc_pkg::AMASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (wr_store)
			store[st_r.wptr] <= fifo_out;
	end

	assign REG_RDATA      = st_r.rdata;
	assign TRACE_NONEMPTY = st_r.count != 5'h00;

	// -----------------------------
	// checks
	// -----------------------------
	sequence s_store;
		fifo_valid;
	endsequence
	property p_wptr_step;
		@(posedge CLK) disable iff (!NRST) s_store |=> st_r.wptr == $past(st_r.wptr) + 4'h1;
	endproperty
	a_wptr_step: assert property (p_wptr_step) else $error("write pointer did not step");
	property p_branch_only;
		@(posedge CLK) disable iff (!NRST) !bus_mode && BUS_END.valid && !BRANCH_TAKEN
			|-> !cand_valid;
	endproperty
	a_branch_only: assert property (p_branch_only) else $error("bus record in branch mode");
	property p_branch_rec;
		@(posedge CLK) disable iff (!NRST) !bus_mode && BRANCH_TAKEN
			|-> cand_valid && cand.addr == BRANCH_SRC && !cand.is_bus;
	endproperty
	a_branch_rec: assert property (p_branch_rec) else $error("branch not recorded");
	property p_branch_clean;
		@(posedge CLK) disable iff (!NRST) cand_valid && !cand.is_bus
			|-> cand.data == '0 && cand.clks == '0 && cand.irq == '0;
	endproperty
	a_branch_clean: assert property (p_branch_clean) else $error("branch record has bus fields");
	property p_full;
		@(posedge CLK) disable iff (!NRST) bus_mode && st_r.ctrl[otc_pkg::CTRL_FULL]
			&& !st_r.ctrl[otc_pkg::CTRL_ADDR_EN] && BUS_END.valid |-> cand_valid;
	endproperty
	a_full: assert property (p_full) else $error("full capture dropped a cycle");
	property p_sup_fetch;
		@(posedge CLK) disable iff (!NRST) bus_mode && !st_r.ctrl[otc_pkg::CTRL_FULL]
			&& st_r.ctrl[otc_pkg::CTRL_SUP_FETCH] && BUS_END.cls == otc_pkg::CLS_FETCH
			|-> !cand_valid;
	endproperty
	a_sup_fetch: assert property (p_sup_fetch) else $error("suppressed fetch recorded");
	property p_addr;
		@(posedge CLK) disable iff (!NRST) bus_mode && cand_valid && st_r.ctrl[otc_pkg::CTRL_ADDR_EN]
			|-> (BUS_END.addr[23:20] == st_r.amatch[23:20] || st_r.amask[5]);
	endproperty
	a_addr: assert property (p_addr) else $error("address condition ignored");
	property p_bus_rec;
		@(posedge CLK) disable iff (!NRST) bus_mode && cand_valid
			|-> cand.addr == BUS_END.addr && cand.data == BUS_END.data && cand.is_bus;
	endproperty
	a_bus_rec: assert property (p_bus_rec) else $error("bus record fields wrong");
	property p_clks;
		@(posedge CLK) disable iff (!NRST) BUS_START ##1 !BUS_START [*2] |-> clks_now == 8'h03;
	endproperty
	a_clks: assert property (p_clks) else $error("cycle count wrong");
endmodule

// ---- verif/otc_cpu_model.sv ----
// Purpose: processor-side model driving branch and bus-cycle events
// Assumes: one event per cycle, changed just after the rising edge
// Notes:   fields are inverted once an event ends, never left stale
`timescale 1ns/1ns
module otc_cpu_model (
	// clock
	input  wire logic CLK,
	// observed processor signals
	output logic              BRANCH_TAKEN,
	output logic [23:0]       BRANCH_SRC,
	output logic              BUS_START,
	output otc_pkg::otc_bus_t BUS_END
);
	initial begin
		BRANCH_TAKEN = 1'b0;
		BRANCH_SRC   = 24'h0;
		BUS_START    = 1'b0;
		BUS_END      = '0;
	end
	// no wait input: the processor never stalls for the trace side
	task automatic branch(input logic [23:0] a);
		@(posedge CLK);
		BRANCH_TAKEN <= 1'b1;
		BRANCH_SRC   <= a;
		@(posedge CLK);
		BRANCH_TAKEN <= 1'b0;
		BRANCH_SRC   <= ~a;
	endtask
	// n clocks from start edge through end edge inclusive
	task automatic cycle(input otc_pkg::otc_bus_t b, input int n);
		otc_pkg::otc_bus_t e;
		e = b;
		e.valid = 1'b1;
		@(posedge CLK);
		BUS_START <= 1'b1;
		if (n == 1) BUS_END <= e;
		for (int i = 1; i < n; i++) begin
			@(posedge CLK);
			BUS_START <= 1'b0;
			if (i == n - 1) BUS_END <= e;
		end
		@(posedge CLK);
		BUS_START <= 1'b0;
		e = otc_pkg::otc_bus_t'(~e);
		e.valid = 1'b0;
		BUS_END <= e;
	endtask
endmodule

// ---- verif/otc_top_tb.sv ----
// Purpose: self-checking bench for the trace capture block
// Assumes: record readable two cycles after its event
// Notes:   record count is mirrored here to predict status
`timescale 1ns/1ns
module otc_top_tb;
	logic              CLK;
	logic              NRST;
	logic [3:0]        REG_ADDR;
	logic [31:0]       REG_WDATA;
	logic              REG_WR;
	logic              REG_RD;
	logic [31:0]       REG_RDATA;
	logic              TRACE_NONEMPTY;
	logic              BRANCH_TAKEN;
	logic [23:0]       BRANCH_SRC;
	logic              BUS_START;
	otc_pkg::otc_bus_t BUS_END;
	int                errors;
	int                checks_done;
	logic [7:0]        n_rec;

	otc_top dut_u (.CLK(CLK), .NRST(NRST), .BRANCH_TAKEN(BRANCH_TAKEN),
		.BRANCH_SRC(BRANCH_SRC), .BUS_START(BUS_START), .BUS_END(BUS_END),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .TRACE_NONEMPTY(TRACE_NONEMPTY));
	otc_cpu_model cpu_u (.CLK(CLK), .BRANCH_TAKEN(BRANCH_TAKEN),
		.BRANCH_SRC(BRANCH_SRC), .BUS_START(BUS_START), .BUS_END(BUS_END));

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// ----
	// bus tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge CLK);
		REG_WR    <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string m);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge CLK);
		REG_RD   <= 1'b0;
		#1 chk(REG_RDATA, e, m);
	endtask
	task automatic stat();
		rdc(otc_pkg::OFS_STATUS, {19'h0, (n_rec > 16) ? 5'h10 : n_rec[4:0],
			n_rec[3:0], 4'h0}, "status");
	endtask
	task automatic ev(input logic [23:0] a, input logic [2:0] c, input int n);
		cpu_u.cycle('{1'b1, a, 16'h5a00 | 16'(c), c[0], c,
			otc_pkg::otc_cls_t'(c), 8'h80 >> c}, n);
		repeat (2) @(posedge CLK);
	endtask
	task automatic pos(input logic [3:0] p, input logic [31:0] e);
		wr(otc_pkg::OFS_RPOS, {28'h0, p});
		rdc(otc_pkg::OFS_RADDR, e, "entry address");
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic s_reset();
		rdc(otc_pkg::OFS_CTRL, 32'h0, "ctrl reset");
		wr(otc_pkg::OFS_STATUS, 32'h1);
		stat();
		rdc(4'hf, 32'h0, "unmapped");
		chk({31'h0, TRACE_NONEMPTY}, 32'h0, "empty flag");
	endtask
	task automatic s_branch();
		wr(otc_pkg::OFS_CTRL, 32'h3c);
		cpu_u.branch(24'h00abcd);
		ev(24'h001000, 3'h2, 1);
		n_rec = 1;
		stat();
		pos(4'h0, 32'h00abcd);
		rdc(otc_pkg::OFS_RINFO, 32'h0, "branch info");
		chk({31'h0, TRACE_NONEMPTY}, 32'h1, "nonempty flag");
	endtask
	task automatic s_bus();
		wr(otc_pkg::OFS_CTRL, 32'h1);
		for (int c = 0; c < 5; c++) begin
			ev(24'h100000 + 24'(c), 3'(c), c + 1);
			pos(4'h0, 32'h80100000 + 32'(c));
			rdc(otc_pkg::OFS_RDATA, {8'h80 >> c, 8'h0, 16'h5a00 | 16'(c)}, "data");
			rdc(otc_pkg::OFS_RINFO, {16'h0, 8'(c + 1), c[0], 3'(c), 1'b0, 3'(c)},
				"info");
		end
		n_rec = 6;
		stat();
	endtask
	task automatic s_filter();
		logic [2:0] cm [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
		for (int k = 0; k < 4; k++) begin
			wr(otc_pkg::OFS_CTRL, 32'h1 | (32'h4 << k));
			ev(24'h300000, cm[k], 2);
			stat();
		end
		wr(otc_pkg::OFS_CTRL, 32'h3f);
		for (int k = 0; k < 4; k++) ev(24'h300000, cm[k], 2);
		n_rec = 10;
		stat();
	endtask
	task automatic s_addr();
		wr(otc_pkg::OFS_AMATCH, 32'h123456);
		wr(otc_pkg::OFS_AMASK, 32'h3);
		wr(otc_pkg::OFS_CTRL, 32'h41);
		rdc(otc_pkg::OFS_AMATCH, 32'h00123456, "match readback");
		rdc(otc_pkg::OFS_AMASK, 32'h3, "mask readback");
		ev(24'h1234ff, 3'h3, 1);
		ev(24'h1334ff, 3'h3, 1);
		ev(24'h123556, 3'h3, 1);
		n_rec = 11;
		stat();
		pos(4'h0, 32'h801234ff);
	endtask
	task automatic s_wrap();
		wr(otc_pkg::OFS_CTRL, 32'h1);
		for (int i = 0; i < 17; i++) ev(24'h200000 + 24'(i), 3'h3, 1);
		n_rec = 28;
		stat();
		pos(4'h0, 32'h80200010);
		pos(4'hf, 32'h8020000f);
		pos(4'h1, 32'h80200001);
		rdc(otc_pkg::OFS_RPOS, 32'h1, "position readback");
	endtask
	task automatic s_rerst();
		@(posedge CLK);
		NRST <= 1'b0;
		@(posedge CLK);
		NRST <= 1'b1;
		n_rec = 0;
		stat();
		rdc(otc_pkg::OFS_CTRL, 32'h0, "ctrl after reset");
		chk({31'h0, TRACE_NONEMPTY}, 32'h0, "empty after reset");
	endtask
	// hang guard: counts as a mismatch
	initial begin
		repeat (20000) @(posedge CLK);
		errors++;
		wrap_up();
	end
	initial begin
		NRST <= 1'b0;
		REG_ADDR = 4'h0;
		REG_WDATA = 32'h0;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		errors = 0;
		checks_done = 0;
		n_rec = 8'h0;
		repeat (4) @(posedge CLK);
		NRST <= 1'b1;
		s_reset();
		s_branch();
		s_bus();
		s_filter();
		s_addr();
		s_wrap();
		s_rerst();
		wrap_up();
	end
endmodule
